// ### mcjc_core.sv
// Purpose: microcycle clock with three cycle lengths, idle control, manual
//    single step and forced-jump (jam) sequencing, Avalon-MM register slave
// Assumes: microword and jam causes come from logic on clk_sys; slave
//    acknowledge and maintenance switch are pins
// Notes: every delay line and one-shot is a down counter on clk_sys
//
// Notes on behaviour
// - a cycle starts with a base pulse of about 40 ns
// - short length: delayed base pulse leaves as phase one and ends the cycle
// - middle length: no phase one; phase two ends the cycle
// - long length: phase two does not end the cycle; phase three ends cycle
// - microword load and timing state clocked on every cycle end, ungated
// - data path and interface strobes gate the phase pulses by microword bits
// - end-of-cycle pulses go out to the status flag logic
// - at cycle end: continue if no stop condition, else set idle and stop
// - halt bit or halt request: finish cycle, load word, wait for restart
// - restart accepted only when fully stopped, never a partial pulse
// - slave acknowledge restarts first; other sources lower, each enabled except the jam restart
// - manual mode: switch starts one sequence; idle state untouched
// - after halt and restart the loaded microword continues, pointer kept
// - errors or power-up stop normal timing and force a fixed address
// - jam flags set by bus errors or power events; these trigger the jam
// - during jam: pointer set/clear, trap clear, flag clock
// - jam end releases pointer; 100 ns later word load and restart pulse
// - restart pulse clears the timeout flag if it caused the jam; restarts
//
// Implementation choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module mcjc_core #(
   parameter int DL2_CYC = mcjc_pkg::DL2_CYC_DEF,
   parameter int DL3_CYC = mcjc_pkg::DL3_CYC_DEF,
   parameter int DL4_CYC = mcjc_pkg::DL4_CYC_DEF,
   parameter int JAM_CYC = mcjc_pkg::JAM_CYC_DEF,
   parameter int JST_CYC = mcjc_pkg::JST_CYC_DEF,
   parameter int PTR_W = mcjc_pkg::PTR_W_DEF,
   parameter logic [PTR_W-1:0] ADDR_PWRUP = 9'h001,
   parameter logic [PTR_W-1:0] ADDR_BUS_ERR = 9'h002,
   parameter logic [PTR_W-1:0] ADDR_NO_RESP = 9'h003
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire mcjc_pkg::mcjc_uword_s uword,
   input wire logic halt_req,
   input wire logic restart_req,
   input wire logic slave_acknowledge,
   input wire logic maint_switch_n,
   input wire mcjc_pkg::mcjc_cause_s cause,
   output logic phase_pulse_one,
   output logic phase_pulse_two,
   output logic phase_pulse_three,
   output logic cycle_end_pulse,
   output logic end_of_cycle_reclock,
   output logic dp_strobe,
   output logic if_strobe,
   output logic idle_state,
   output logic forced_jump_pulse,
   output logic [PTR_W-1:0] ptr_set,
   output logic [PTR_W-1:0] ptr_clear,
   output logic trap_irq_clear,
   output logic fault_flag_clock,
   output logic forced_word_load_strobe,
   output logic forced_restart_pulse,
   output logic no_response_clear,
   output logic irq
);
   localparam int CW = mcjc_pkg::CNT_W;
   localparam logic [CW-1:0] PW_N = CW'(mcjc_pkg::PULSE_CYC - 1);
   localparam logic [CW-1:0] D2_N = CW'(DL2_CYC - 1);
   localparam logic [CW-1:0] D3_N = CW'(DL3_CYC - 1);
   localparam logic [CW-1:0] D4_N = CW'(DL4_CYC - 1);
   localparam logic [CW-1:0] JAM_N = CW'(JAM_CYC - 1);
   localparam logic [CW-1:0] GAP_N = CW'(mcjc_pkg::JAM_GAP_CYC - 1);
   localparam logic [CW-1:0] JST_N = CW'(JST_CYC - 1);

   // counter width and the 9-bit jam addresses bound the parameters
   if (DL2_CYC < 1 || DL3_CYC < 1 || DL4_CYC < 1 || JAM_CYC < 1 || JST_CYC < 1 ||
       DL2_CYC > 255 || DL3_CYC > 255 || DL4_CYC > 255 || JAM_CYC > 255 ||
       JST_CYC > 255 || PTR_W != 9) begin : g_param_check
      $error("mcjc_core: parameter out of range");
   end

   typedef enum logic [2:0] {
      ST_STOP = 3'h0,
      ST_BASE = 3'h1,
      ST_DL2 = 3'h3,
      ST_DL3 = 3'h2,
      ST_DL4 = 3'h6
   } mcjc_clk_e;
   typedef enum logic [1:0] {
      J_IDLE = 2'h0,
      J_PULSE = 2'h1,
      J_GAP = 2'h3,
      J_START = 2'h2
   } mcjc_jam_e;

   mcjc_clk_e st_r;
   mcjc_jam_e jst_r;
   logic [CW-1:0] cnt_r;
   logic [CW-1:0] jcnt_r;
   logic [CW-1:0] cnt_nxt;
   logic [2:0] ack_sync_r;
   logic [2:0] sw_sync_r;
   logic [mcjc_pkg::CTRL_W-1:0] ctrl_r;
   logic [mcjc_pkg::IRQ_W-1:0] irq_stat_r;
   logic [mcjc_pkg::IRQ_W-1:0] irq_en_r;
   logic sw_restart_r;
   logic jam_restart_r;
   logic jam_bus_error_flag_r;
   logic jam_powerup_flag_r;
   logic timeout_cause_r;
   logic [mcjc_pkg::IRQ_W-1:0] irq_evt;
   logic reg_req;
   logic reg_do;
   logic cyc_end;
   logic stop_cond;
   logic manual;
   logic ack_edge;
   logic sw_press;
   logic start_norm;
   logic start_man;
   logic ph1_nxt;
   logic ph2_nxt;
   logic ph3_nxt;
   logic jam_trig;
   logic [PTR_W-1:0] jam_addr;
   mcjc_pkg::mcjc_len_e len;

   assign len = mcjc_pkg::mcjc_len_e'(uword.clk_len);
   assign manual = ctrl_r[mcjc_pkg::CTRL_MANUAL];

   // pins: two flops before any logic; third stage only for edge detect
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ack_sync_r <= 3'h0;
         sw_sync_r <= 3'h0;
      end else begin
         ack_sync_r <= {ack_sync_r[1:0], slave_acknowledge};
         sw_sync_r <= {sw_sync_r[1:0], ~maint_switch_n};
      end
   end
   assign ack_edge = ack_sync_r[1] & ~ack_sync_r[2];
   assign sw_press = sw_sync_r[1] & ~sw_sync_r[2];

   // phase pulses are next-state terms so the registered outputs align
   always_comb begin
      ph1_nxt = 1'b0;
      ph2_nxt = 1'b0;
      ph3_nxt = 1'b0;
      if (cnt_r == '0) begin
         unique case (st_r)
            ST_DL2: ph1_nxt = (len == mcjc_pkg::CL_SHORT);
            ST_DL3: ph2_nxt = 1'b1;
            ST_DL4: ph3_nxt = 1'b1;
            default: ;
         endcase
      end
   end
   assign cyc_end = ph1_nxt | (ph2_nxt & (len == mcjc_pkg::CL_MIDDLE)) | ph3_nxt;
   assign stop_cond = uword.microword_clock_halt_bit | halt_req |
                      ctrl_r[mcjc_pkg::CTRL_HALT] | (jst_r != J_IDLE) | jam_trig;
   // acknowledge first, then lower sources, all enabled except the jam restart
   assign start_norm = (st_r == ST_STOP) && idle_state && !manual &&
                       ((ack_edge && ctrl_r[mcjc_pkg::CTRL_ACK_EN]) || jam_restart_r ||
                        (ctrl_r[mcjc_pkg::CTRL_RST_EN] && (restart_req || sw_restart_r)));
   assign start_man = (st_r == ST_STOP) && manual && sw_press;

   // one counter models all delay lines
   always_comb begin
      cnt_nxt = cnt_r - 1'b1;
      if (cnt_r == '0) begin
         unique case (st_r)
            ST_STOP: cnt_nxt = PW_N;
            ST_BASE: cnt_nxt = D2_N;
            ST_DL2: cnt_nxt = (len == mcjc_pkg::CL_SHORT) ? PW_N : D3_N;
            ST_DL3: cnt_nxt = (len == mcjc_pkg::CL_MIDDLE) ? PW_N : D4_N;
            ST_DL4: cnt_nxt = PW_N;
            default: cnt_nxt = PW_N;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= ST_STOP;
         cnt_r <= '0;
      end else if (st_r == ST_STOP) begin
         cnt_r <= PW_N;
         if (start_norm || start_man)
            st_r <= ST_BASE;
      end else begin
         cnt_r <= cnt_nxt;
         if (cnt_r == '0) begin
            unique case (st_r)
               ST_BASE: st_r <= ST_DL2;
               ST_DL2: st_r <= ph1_nxt ? ST_STOP : ST_DL3;
               ST_DL3: st_r <= (len == mcjc_pkg::CL_MIDDLE) ? ST_STOP : ST_DL4;
               ST_DL4: st_r <= ST_STOP;
               default: st_r <= ST_STOP;
            endcase
            // continue unless stopping; manual always stops
            if (cyc_end && !stop_cond && !manual)
               st_r <= ST_BASE;
         end
      end
   end

   // idle set at a stopping cycle end, cleared on normal restart
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n)
         idle_state <= 1'b1;
      else if (start_norm)
         idle_state <= 1'b0;
      else if (cyc_end && stop_cond && !manual)
         idle_state <= 1'b1;
   end

   // ungated load on every cycle end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         phase_pulse_one <= 1'b0;
         phase_pulse_two <= 1'b0;
         phase_pulse_three <= 1'b0;
         cycle_end_pulse <= 1'b0;
         end_of_cycle_reclock <= 1'b0;
         dp_strobe <= 1'b0;
         if_strobe <= 1'b0;
      end else begin
         phase_pulse_one <= ph1_nxt;
         phase_pulse_two <= ph2_nxt;
         phase_pulse_three <= ph3_nxt;
         cycle_end_pulse <= cyc_end;
         end_of_cycle_reclock <= cyc_end;
         dp_strobe <= |(uword.dp_sel & {ph3_nxt, ph2_nxt, ph1_nxt});
         if_strobe <= |(uword.if_sel & {ph3_nxt, ph2_nxt, ph1_nxt});
      end
   end

   // jam flags; set wins over the clear by the restart pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         jam_bus_error_flag_r <= 1'b0;
         jam_powerup_flag_r <= 1'b0;
      end else begin
         if (cause.odd_addr_err || cause.red_zone_ovf)
            jam_bus_error_flag_r <= 1'b1;
         else if (jst_r == J_START)
            jam_bus_error_flag_r <= 1'b0;
         if (cause.start_in_halt || cause.power_restart)
            jam_powerup_flag_r <= 1'b1;
         else if (jst_r == J_START)
            jam_powerup_flag_r <= 1'b0;
      end
   end
   assign jam_trig = (jst_r == J_IDLE) && (jam_bus_error_flag_r || jam_powerup_flag_r ||
                     cause.no_response_timeout_flag || cause.powerup_initialize);
   // address chosen by cause, power-up first
   assign jam_addr = (jam_powerup_flag_r || cause.powerup_initialize) ? ADDR_PWRUP :
                     jam_bus_error_flag_r ? ADDR_BUS_ERR : ADDR_NO_RESP;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         jst_r <= J_IDLE;
         jcnt_r <= '0;
      end else begin
         jcnt_r <= jcnt_r - 1'b1;
         unique case (jst_r)
            J_IDLE: begin
               jcnt_r <= JAM_N;
               if (jam_trig)
                  jst_r <= J_PULSE;
            end
            J_PULSE: if (jcnt_r == '0) begin
               jst_r <= J_GAP;
               jcnt_r <= GAP_N;
            end
            J_GAP: if (jcnt_r == '0) begin
               jst_r <= J_START;
               jcnt_r <= JST_N;
            end
            J_START: if (jcnt_r == '0)
               jst_r <= J_IDLE;
         endcase
      end
   end

   // pointer controls and flag strobes while jam pulse is active
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         forced_jump_pulse <= 1'b0;
         ptr_set <= '0;
         ptr_clear <= '0;
         trap_irq_clear <= 1'b0;
         fault_flag_clock <= 1'b0;
         timeout_cause_r <= 1'b0;
      end else begin
         forced_jump_pulse <= jam_trig || (jst_r == J_PULSE && jcnt_r != '0);
         trap_irq_clear <= jam_trig;
         fault_flag_clock <= jam_trig;
         if (jam_trig) begin
            ptr_set <= jam_addr;
            ptr_clear <= ~jam_addr;
            timeout_cause_r <= cause.no_response_timeout_flag;
         // release pointer controls at jam end
         // outside a jam the pointer is left alone
         end else if (jst_r == J_PULSE && jcnt_r == '0) begin
            ptr_set <= '0;
            ptr_clear <= '0;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         forced_word_load_strobe <= 1'b0;
         forced_restart_pulse <= 1'b0;
         no_response_clear <= 1'b0;
         jam_restart_r <= 1'b0;
      end else begin
         forced_word_load_strobe <= (jst_r == J_GAP) && (jcnt_r == '0);
         forced_restart_pulse <= (jst_r == J_GAP && jcnt_r == '0) ||
                                 (jst_r == J_START && jcnt_r != '0);
         no_response_clear <= (jst_r == J_GAP) && (jcnt_r == '0) && timeout_cause_r;
         // held until the clock is truly stopped
         if (jst_r == J_GAP && jcnt_r == '0)
            jam_restart_r <= 1'b1;
         else if (start_norm)
            jam_restart_r <= 1'b0;
      end
   end

   // bus slave: one wait cycle then answer
   assign reg_req = avs_read | avs_write;
   assign reg_do = reg_req & ~avs_waitrequest;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0000_0000;
      end else begin
         avs_waitrequest <= ~(reg_req & avs_waitrequest);
         if (avs_read && avs_waitrequest) begin
            unique case (avs_address)
               mcjc_pkg::OFS_CTRL: avs_readdata <= 32'(ctrl_r);
               mcjc_pkg::OFS_STAT: avs_readdata <= 32'({jam_powerup_flag_r,
                  jam_bus_error_flag_r, (jst_r != J_IDLE), (st_r != ST_STOP), idle_state});
               mcjc_pkg::OFS_IRQ_STAT: avs_readdata <= 32'(irq_stat_r);
               mcjc_pkg::OFS_IRQ_EN: avs_readdata <= 32'(irq_en_r);
               default: avs_readdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= mcjc_pkg::CTRL_RESET;
         irq_en_r <= '0;
         sw_restart_r <= 1'b0;
      end else begin
         if (reg_do && avs_write && avs_byteenable[0]) begin
            if (avs_address == mcjc_pkg::OFS_CTRL)
               ctrl_r <= avs_writedata[mcjc_pkg::CTRL_W-1:0];
            if (avs_address == mcjc_pkg::OFS_IRQ_EN)
               irq_en_r <= avs_writedata[mcjc_pkg::IRQ_W-1:0];
         end
         if (reg_do && avs_write && avs_byteenable[0] &&
             avs_address == mcjc_pkg::OFS_RESTART && avs_writedata[0])
            sw_restart_r <= 1'b1;
         else if (start_norm || start_man)
            sw_restart_r <= 1'b0;
      end
   end

   // sticky events; a set in the clearing cycle survives
   assign irq_evt[mcjc_pkg::IRQ_STOPPED] = cyc_end && stop_cond && !manual;
   assign irq_evt[mcjc_pkg::IRQ_FORCED_RESTART_PULSE] = jam_trig;
   assign irq_evt[mcjc_pkg::IRQ_JAM_DONE] = (jst_r == J_START) && (jcnt_r == '0);
   assign irq_evt[mcjc_pkg::IRQ_BUS_ERR] = cause.odd_addr_err | cause.red_zone_ovf;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         irq_stat_r <= '0;
         irq <= 1'b0;
      end else begin
         if (reg_do && avs_write && avs_byteenable[0] &&
             avs_address == mcjc_pkg::OFS_IRQ_CLR)
            irq_stat_r <= (irq_stat_r & ~avs_writedata[mcjc_pkg::IRQ_W-1:0]) | irq_evt;
         else
            irq_stat_r <= irq_stat_r | irq_evt;
         irq <= |(irq_stat_r & irq_en_r);
      end
   end

   base_width_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(st_r == ST_BASE) |->
         (st_r == ST_BASE) [*8] ##1 (st_r == ST_BASE) [*2] ##1 (st_r == ST_DL2))
      else $error("base pulse width wrong");
   short_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      phase_pulse_one |-> cycle_end_pulse && !phase_pulse_two)
      else $error("phase one without cycle end");
   mid_no_p1_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      phase_pulse_two && cycle_end_pulse |-> !phase_pulse_one && !phase_pulse_three)
      else $error("middle cycle pulses wrong");
   long_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      phase_pulse_three |-> cycle_end_pulse && $past(st_r) == ST_DL4)
      else $error("phase three not ending long cycle");
   reload_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      cycle_end_pulse == end_of_cycle_reclock)
      else $error("reclock not tied to cycle end");
   strobe_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (dp_strobe || if_strobe) |->
         (phase_pulse_one || phase_pulse_two || phase_pulse_three))
      else $error("strobe without phase pulse");
   stop_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      idle_state && st_r == ST_STOP && !start_man |=> !phase_pulse_one && !phase_pulse_two)
      else $error("pulse while idle");
   restart_stop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(st_r == ST_BASE) && !cycle_end_pulse |-> $past(st_r) == ST_STOP)
      else $error("restart from running clock");
   manual_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      manual && !start_norm |=> $stable(idle_state))
      else $error("manual step changed idle");
   jam_ptr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      forced_jump_pulse |-> (ptr_set == ~ptr_clear))
      else $error("pointer controls not complementary");
   ptr_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !forced_jump_pulse |-> ptr_set == '0 && ptr_clear == '0)
      else $error("pointer controls outside jam");
   jam_gap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(forced_jump_pulse) |-> ##[24:26] forced_word_load_strobe)
      else $error("jam gap wrong");
   jam_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(forced_restart_pulse) |-> forced_word_load_strobe)
      else $error("restart pulse without word load");
   short_c: cover property (@(posedge clk_sys) phase_pulse_one);
   long_c: cover property (@(posedge clk_sys) phase_pulse_three);
   jam_c: cover property (@(posedge clk_sys) forced_restart_pulse ##[1:400] cycle_end_pulse);
   manual_c: cover property (@(posedge clk_sys) start_man);
endmodule // mcjc_core
`default_nettype wire

// ### mcjc_pkg.sv
// Purpose: shared constants and carriers of the microcycle clock and jam control
// Assumes: 250 MHz system clock, Avalon-MM register slave with 32-bit data
// Notes: delay-line figures are expressed as clock-cycle counts
package mcjc_pkg;
   localparam int CLK_NS = 4;
   localparam int PULSE_NS = 40;
   localparam int JAM_GAP_NS = 100;
   // least times round up
   localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
   localparam int JAM_GAP_CYC = (JAM_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int DL2_CYC_DEF = 3;
   localparam int DL3_CYC_DEF = 20;
   localparam int DL4_CYC_DEF = 20;
   localparam int JAM_CYC_DEF = 12;
   localparam int JST_CYC_DEF = 4;
   localparam int CNT_W = 8;
   localparam int PTR_W_DEF = 9;

   localparam logic [4:0] OFS_CTRL = 5'h00;
   localparam logic [4:0] OFS_STAT = 5'h04;
   localparam logic [4:0] OFS_IRQ_STAT = 5'h08;
   localparam logic [4:0] OFS_IRQ_CLR = 5'h0c;
   localparam logic [4:0] OFS_IRQ_EN = 5'h10;
   localparam logic [4:0] OFS_RESTART = 5'h14;

   localparam int CTRL_W = 4;
   localparam int CTRL_MANUAL = 0;
   localparam int CTRL_HALT = 1;
   localparam int CTRL_RST_EN = 2;
   localparam int CTRL_ACK_EN = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h8;

   localparam int IRQ_W = 4;
   localparam int IRQ_STOPPED = 0;
   localparam int IRQ_FORCED_RESTART_PULSE = 1;
   localparam int IRQ_JAM_DONE = 2;
   localparam int IRQ_BUS_ERR = 3;

   typedef enum logic [1:0] {
      CL_SHORT = 2'h0,
      CL_MIDDLE = 2'h1,
      CL_LONG = 2'h2,
      CL_LONG_ALT = 2'h3
   } mcjc_len_e;

   typedef struct packed {
      logic [1:0] clk_len;
      logic microword_clock_halt_bit;
      logic [2:0] dp_sel;
      logic [2:0] if_sel;
   } mcjc_uword_s;

   typedef struct packed {
      logic odd_addr_err;
      logic red_zone_ovf;
      logic start_in_halt;
      logic power_restart;
      logic no_response_timeout_flag;
      logic powerup_initialize;
   } mcjc_cause_s;
endpackage

// ### mcjc_slave_model.sv
// Purpose: bus slave response model driving the acknowledge pin
// Assumes: bench raises req while a transfer waits for its answer
// Notes: answers dly+1 cycles after req rises; released pin goes back to inactive
`timescale 1ns/1ps
`default_nettype none
module mcjc_slave_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic req,
   input wire logic [3:0] dly,
   output logic slave_acknowledge
);
   logic [3:0] cnt_r;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 4'h0;
         slave_acknowledge <= 1'b0;
      end else begin
         cnt_r <= req ? cnt_r + 4'h1 : 4'h0;
         slave_acknowledge <= req && (cnt_r >= dly);
      end
   end
endmodule // mcjc_slave_model
`default_nettype wire

// ### microcycle_clock_and_jam_control_tb.sv
// Purpose: self-checking bench of the microcycle clock and jam control
// Assumes: short delay parameters so that jam and long cycles stay brief
// Notes: uword is changed only while the clock is stopped
`timescale 1ns/1ps
`default_nettype none
module microcycle_clock_and_jam_control_tb;
   localparam int DL4 = 2;
   localparam int JAM = 2;
   logic clk_sys = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q, seed = 32'h4;
   mcjc_pkg::mcjc_uword_s uw = '0;
   mcjc_pkg::mcjc_cause_s cs = '0;
   logic halt_req = 1'b0, restart_req = 1'b0, maint_switch_n = 1'b1, sreq = 1'b0, ack, jp_q = 1'b0;
   logic ph1, ph2, ph3, ce, rc, dps, ifs, idle, jp, trc, ffc, wls, frp, nrc, irq, enr = 1'b0;
   logic [3:0] dly = 4'h0;
   logic [8:0] pset, pclr, ea = 9'h0;
   int miscompares = 0, checks = 0, cyc = 0, t2 = 0, tf = 0, jw = 0, ends = 0, e0 = 0;
   mcjc_core #(.DL3_CYC(2), .DL4_CYC(DL4), .JAM_CYC(JAM)) mcjc_core_i (.clk_sys(clk_sys),
      .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .uword(uw), .halt_req(halt_req),
      .restart_req(restart_req), .slave_acknowledge(ack), .maint_switch_n(maint_switch_n),
      .cause(cs), .phase_pulse_one(ph1), .phase_pulse_two(ph2), .phase_pulse_three(ph3),
      .cycle_end_pulse(ce), .end_of_cycle_reclock(rc), .dp_strobe(dps), .if_strobe(ifs),
      .idle_state(idle), .forced_jump_pulse(jp), .ptr_set(pset), .ptr_clear(pclr),
      .trap_irq_clear(trc), .fault_flag_clock(ffc), .forced_word_load_strobe(wls),
      .forced_restart_pulse(frp), .no_response_clear(nrc), .irq(irq));
   mcjc_slave_model mcjc_slave_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .req(sreq),
      .dly(dly), .slave_acknowledge(ack));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic exp_end(input logic [1:0] l, input logic a, b, c);
      return (l == 2'h0) ? a : ((l == 2'h1) ? b : c);
   endfunction
   function automatic logic [8:0] jam_addr(input mcjc_pkg::mcjc_cause_s c);
      if (c.powerup_initialize | c.start_in_halt | c.power_restart) return 9'h001;
      if (c.odd_addr_err | c.red_zone_ovf) return 9'h002;
      return 9'h003;
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic delta(input int n);
      chk(ends - e0, n);
      e0 = ends;
   endtask
   task automatic ack_start();
      dly <= 4'(xs() % 6);
      sreq <= 1'b1;
      wt(12);
      sreq <= 1'b0;
      wt(100);
   endtask
   task automatic complete_run();
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (ph2 === 1'b1) t2 = cyc;
      if (ce === 1'b1) ends++;
      if (ph1 | ph2 | ph3 | ce) begin
         chk({ce, rc, ph1 & (uw.clk_len != 2'h0)},
             {{2{exp_end(uw.clk_len, ph1, ph2, ph3)}}, 1'b0});
         chk({dps, ifs}, {|(uw.dp_sel & {ph3, ph2, ph1}), |(uw.if_sel & {ph3, ph2, ph1})});
      end
      if (ph3 === 1'b1) chk(cyc - t2, DL4);
      if (jp === 1'b1) begin
         jw++;
         if (!jp_q) chk({trc, ffc, pset, pclr}, {2'b11, ea, ~ea});
      end else if (jp_q) begin
         chk({jw, pset, pclr}, {JAM, 18'h0});
         tf = cyc;
         jw = 0;
      end
      if (wls === 1'b1) chk({frp, nrc, cyc - tf}, {1'b1, enr, mcjc_pkg::JAM_GAP_CYC});
      jp_q = jp;
   end
   initial begin
      wt(20000);
      miscompares++;
      complete_run();
   end
   initial begin
      wt(10);
      rst_n <= 1'b1;
      chk(idle, 1'b1);
      bus(1'b0, mcjc_pkg::OFS_CTRL, 32'h0);
      chk(q, 32'h8);
      bus(1'b0, 5'h1c, 32'h0);
      chk(q, 32'h0);
      for (int l = 0; l < 4; l++) begin
         uw <= {2'(l), 1'b1, 6'(xs())};
         ack_start();
         delta(1);
      end
      uw <= {2'h0, 1'b0, 6'(xs())};
      ack_start();
      chk(ends - e0 > 1, 1'b1);
      halt_req <= 1'b1;
      wt(40);
      e0 = ends;
      wt(60);
      delta(0);
      restart_req <= 1'b1;
      wt(40);
      delta(0);
      bus(1'b1, mcjc_pkg::OFS_CTRL, 32'hc);
      wt(1);
      restart_req <= 1'b0;
      wt(60);
      delta(1);
      bus(1'b1, mcjc_pkg::OFS_RESTART, 32'h1);
      wt(60);
      delta(1);
      bus(1'b1, mcjc_pkg::OFS_CTRL, 32'h9);
      maint_switch_n <= 1'b0;
      wt(5);
      maint_switch_n <= 1'b1;
      wt(60);
      delta(1);
      chk(idle, 1'b1);
      ack_start();
      delta(0);
      bus(1'b1, mcjc_pkg::OFS_CTRL, 32'h8);
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, mcjc_pkg::OFS_IRQ_CLR, 32'hf);
         bus(1'b1, mcjc_pkg::OFS_IRQ_EN, (i < 5) ? 32'h2 : 32'h0);
         chk(irq, 1'b0);
         ea = jam_addr(6'h1 << i);
         enr = (i == 1);
         cs <= 6'h1 << i;
         wt(1);
         cs <= '0;
         wt(100);
         chk(irq, i < 5);
         bus(1'b0, mcjc_pkg::OFS_IRQ_STAT, 32'h0);
         chk(q[mcjc_pkg::IRQ_FORCED_RESTART_PULSE], 1'b1);
      end
      complete_run();
   end
endmodule // microcycle_clock_and_jam_control_tb
`default_nettype wire
